// ### verilog/adr_params.svh
// Offsets, field positions, reset values and sample phases of the receiver
`ifndef ADR_PARAMS_SVH
`define ADR_PARAMS_SVH

// Register byte addresses
`define ADR_OFF_CTRL 32'h0000_0000
`define ADR_OFF_STAT 32'h0000_0004
`define ADR_OFF_DATA 32'h0000_0008

// Control register fields
`define ADR_CTL_LEN 0
`define ADR_CTL_WAKE 1
`define ADR_CTL_QSTART 2
`define ADR_CTL_FULLIE 3
`define ADR_CTL_QIE 4
`define ADR_CTL_STBY 5
`define ADR_CTL_SRST 7
`define ADR_CTRL_RST 8'h00

// Status register fields
`define ADR_ST_FULL 0
`define ADR_ST_QUIET 1
`define ADR_ST_NOISE 2
`define ADR_ST_FRAME 3
`define ADR_ST_STBY 4

// Oversample phases, zero based: phase n of 16 is held as n-1
`define ADR_PH3 4'h2
`define ADR_PH5 4'h4
`define ADR_PH7 4'h6
`define ADR_PH8 4'h7
`define ADR_PH9 4'h8
`define ADR_PH10 4'h9
`define ADR_PH16 4'hF

// Index of last data bit and quiet-line bit counts per character length
`define ADR_LAST8 4'h7
`define ADR_LAST9 4'h8
`define ADR_QUIET8 4'hA
`define ADR_QUIET9 4'hB

// Bus responses
`define ADR_RESP_OKAY 2'b00
`define ADR_RESP_SLVERR 2'b10

`endif

// ### verilog/adr_pkg.sv
// Types shared by the receiver files
package adr_pkg;
    // Receiver sequencing states
    typedef enum logic [1:0]
    {
        ADR_SEARCH = 2'b00,
        ADR_START = 2'b01,
        ADR_DATA = 2'b10,
        ADR_STOP = 2'b11
    } adr_state_t;
endpackage : adr_pkg

// ### verilog/adr_vote3.sv
// Three-sample majority vote with disagreement detect
`timescale 1ns/1ps
module adr_vote3
(
    input wire logic [2:0] samples,
    output logic majority,
    output logic disagree
);
    // Two or more ones win the vote
    assign majority = (samples[2] & samples[1]) | (samples[2] & samples[0]) | (samples[1] & samples[0]);
    // Any mix of values counts as noise
    assign disagree = (samples != 3'b000) && (samples != 3'b111);
endmodule : adr_vote3

// ### verilog/adr_receiver.sv
// Oversampling serial receiver with data recovery, standby wakeup and AXI4-Lite registers
//
// Function
// - Sample line on sixteen-times oversample tick
// - Resync phase after start and confirmed fall
// - Start edge is zero after three ones
// - Verify start at phases 3,5,7
// - Failed verification restarts start bit search
// - Data bit majority of phases 8-10
// - Late start ones only raise noise
// - Stop majority zero flags framing fault
// - Framing fault rises with receive full
// - Standby suppresses all receiver interrupt requests
// - Address mark clears standby, sets full
// - Waking quiet character sets no flags
// - Select where quiet bit counting starts
// - Standby on idle line may wake at once
// - Full flag on transfer, interrupt when enabled
// - Quiet flag after ten or eleven ones
// - Wake select one means address mark
// - Quiet start select one means after stop
// - Length select one means nine data bits
`timescale 1ns/1ps
`include "adr_params.svh"
module adr_receiver
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic oversample_tick,
    input wire logic rx_pin,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic rx_full_irq,
    output logic quiet_irq
);
    // Line synchroniser, second stage is the only reader of the first
    logic rx_meta_reg, rx_sync_reg;
    // Sequencer state
    adr_pkg::adr_state_t state_reg, state_next;
    logic [3:0] phase_reg, phase_next;
    logic [2:0] hist_reg;       // Last three line samples
    logic [1:0] vs_reg;         // Start verify samples at phases 3 and 5
    logic [1:0] ds_reg;         // Bit samples at phases 8 and 9
    logic [3:0] bitcnt_reg;
    logic [8:0] shift_reg;
    logic char_noise_reg;       // Noise seen in the start or data bits of the current character
    logic watch_reg;            // Previous data bit voted one
    logic edge_seen_reg;
    logic [3:0] edge_age_reg;
    logic [3:0] idle_cnt_reg, idle_cnt_next;
    logic idle_armed_reg;
    // Software-visible state
    logic [7:0] ctrl_reg;
    logic standby_request_bit_reg;
    logic rx_full_flag_reg, quiet_flag_reg, noise_flag_reg, framing_fault_flag_reg;
    logic [8:0] rx_data_buffer_reg;
    // Bus slave state
    logic aw_held_reg, w_held_reg;
    logic [31:0] waddr_reg, wdata_reg;
    logic [3:0] wstrb_reg;
    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic full_irq_reg, quiet_irq_reg;

    // Control fields
    wire char_len_sel = ctrl_reg[`ADR_CTL_LEN];
    wire wake_sel = ctrl_reg[`ADR_CTL_WAKE];
    wire quiet_count_start_select = ctrl_reg[`ADR_CTL_QSTART];
    wire rx_full_irq_enable = ctrl_reg[`ADR_CTL_FULLIE];
    wire quiet_irq_enable = ctrl_reg[`ADR_CTL_QIE];

    // The sequencer and its sample registers advance only on the tick, and the tick is gated by the clock enable
    wire tick = oversample_tick & clk_en;
    wire sample = rx_sync_reg;
    wire in_search = (state_reg == adr_pkg::ADR_SEARCH);
    wire in_start = (state_reg == adr_pkg::ADR_START);
    wire in_data = (state_reg == adr_pkg::ADR_DATA);
    wire in_stop = (state_reg == adr_pkg::ADR_STOP);

    // Votes: start verify uses phases 3,5,7, bit recovery uses phases 8,9,10
    logic start_maj, start_dis, bit_maj, bit_dis;
    adr_vote3 u_start_vote
    (
        .samples({vs_reg, sample}),
        .majority(start_maj),
        .disagree(start_dis)
    );
    adr_vote3 u_bit_vote
    (
        .samples({ds_reg, sample}),
        .majority(bit_maj),
        .disagree(bit_dis)
    );

    // Sequencing events
    wire start_edge = in_search & tick & ~sample & (hist_reg == 3'b111);
    wire verify_pt = in_start & tick & (phase_reg == `ADR_PH7);
    wire start_fail = verify_pt & start_maj;
    wire vote_pt = tick & ~in_search & (phase_reg == `ADR_PH10);
    wire bit_end = tick & (phase_reg == `ADR_PH16);
    wire [3:0] last_bit = char_len_sel ? `ADR_LAST9 : `ADR_LAST8;
    wire char_done = vote_pt & in_stop;
    wire fall_edge = tick & watch_reg & hist_reg[0] & ~sample;
    // Resync only when the falling edge is confirmed by a zero vote
    wire resync = vote_pt & in_data & edge_seen_reg & ~bit_maj & (edge_age_reg != 4'hF);

    // Quiet-line bit counting
    wire srch_bit = in_search & tick & sample & (phase_reg == `ADR_PH16);
    wire bit1_evt = vote_pt & (in_data | in_stop) & bit_maj;
    wire bit0_evt = vote_pt & (in_data | in_stop) & ~bit_maj;
    // Select one restarts the count at the stop bit, so character ones never count
    wire idle_clr = (in_search & tick & ~sample) | bit0_evt | (char_done & quiet_count_start_select);
    wire idle_inc = srch_bit | (bit1_evt & ~quiet_count_start_select);
    wire [3:0] idle_thr = char_len_sel ? `ADR_QUIET9 : `ADR_QUIET8;
    wire idle_at = (idle_cnt_reg == idle_thr);
    wire idle_hit = idle_inc & ~idle_clr & (idle_cnt_reg == idle_thr - 4'h1);
    assign idle_cnt_next = idle_clr ? 4'h0 : ((idle_inc & ~idle_at) ? idle_cnt_reg + 4'h1 : idle_cnt_reg);

    // Wakeup: a standing idle count wakes at once, as the line may already be quiet
    wire idle_wake = standby_request_bit_reg & ~wake_sel & (idle_hit | idle_at) & clk_en;
    wire addr_wake = char_done & standby_request_bit_reg & wake_sel & shift_reg[8];
    wire deliver = char_done & (~standby_request_bit_reg | addr_wake);
    wire quiet_set = idle_hit & idle_armed_reg & ~standby_request_bit_reg;
    wire [8:0] char_data = char_len_sel ? shift_reg : {1'b0, shift_reg[8:1]};
    wire noise_now = (verify_pt & ~start_maj & start_dis) | (vote_pt & in_start & (bit_maj | bit_dis))
                   | (vote_pt & in_data & bit_dis);

    // Bus decode
    wire wr_do = clk_en & aw_held_reg & w_held_reg & ~bvalid_reg;
    wire w_ctrl = (waddr_reg == `ADR_OFF_CTRL);
    wire w_stat = (waddr_reg == `ADR_OFF_STAT);
    wire w_hit = w_ctrl | w_stat | (waddr_reg == `ADR_OFF_DATA);
    wire wr_ctrl = wr_do & w_ctrl & wstrb_reg[0];
    wire [3:0] flag_clr = (wr_do & w_stat & wstrb_reg[0]) ? wdata_reg[3:0] : 4'h0;
    wire srst = wr_ctrl & wdata_reg[`ADR_CTL_SRST];
    wire aw_take = s_axi_awvalid & awready_reg;
    wire w_take = s_axi_wvalid & wready_reg;
    wire rd_take = s_axi_arvalid & arready_reg;
    wire aw_held_next = (aw_held_reg | aw_take) & ~wr_do;
    wire w_held_next = (w_held_reg | w_take) & ~wr_do;
    wire bvalid_next = wr_do | (bvalid_reg & ~s_axi_bready);
    wire rvalid_next = rd_take | (rvalid_reg & ~s_axi_rready);
    wire [4:0] stat_word = {standby_request_bit_reg, framing_fault_flag_reg, noise_flag_reg,
                            quiet_flag_reg, rx_full_flag_reg};
    wire r_ctrl = (s_axi_araddr == `ADR_OFF_CTRL);
    wire r_stat = (s_axi_araddr == `ADR_OFF_STAT);
    wire r_data = (s_axi_araddr == `ADR_OFF_DATA);
    // Standby reads back from its own register so a wakeup shows at once
    wire [31:0] rd_word = r_ctrl ? {24'h00_0000, 1'b0, ctrl_reg[6], standby_request_bit_reg, ctrl_reg[4:0]} :
                          r_stat ? {27'h000_0000, stat_word} :
                          r_data ? {23'h00_0000, rx_data_buffer_reg} : 32'h0000_0000;

    // Next state of the sequencer
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            adr_pkg::ADR_SEARCH:
            begin
                // Wait for a zero after three ones
                if (start_edge)
                    state_next = adr_pkg::ADR_START;
            end
            adr_pkg::ADR_START:
            begin
                // A failed check drops back to search
                if (start_fail)
                    state_next = adr_pkg::ADR_SEARCH;
                else if (bit_end)
                    state_next = adr_pkg::ADR_DATA;
            end
            adr_pkg::ADR_DATA:
            begin
                if (bit_end && (bitcnt_reg == last_bit))
                    state_next = adr_pkg::ADR_STOP;
            end
            adr_pkg::ADR_STOP:
            begin
                // Stop is judged at phase 10; searching early tolerates fast senders
                if (char_done)
                    state_next = adr_pkg::ADR_SEARCH;
            end
        endcase
    end

    // Phase counter: in search it times quiet bits, restarting on any zero
    // Restarting at the stop vote keeps the stop bit's tail from counting as a quiet bit
    assign phase_next = !tick ? phase_reg :
                        (in_search ? (sample ? phase_reg + 4'h1 : 4'h0) :
                        ((start_fail | char_done) ? 4'h0 :
                        (resync ? edge_age_reg + 4'h1 : phase_reg + 4'h1)));

    // Line synchroniser
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
        end
        else if (clk_en)
        begin
            rx_meta_reg <= rx_pin;
            rx_sync_reg <= rx_meta_reg;
        end
    end

    // Sequencer and sampling registers
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg <= adr_pkg::ADR_SEARCH;
            phase_reg <= 4'h0;
            hist_reg <= 3'b000;
            vs_reg <= 2'b00;
            ds_reg <= 2'b00;
            bitcnt_reg <= 4'h0;
            shift_reg <= 9'h000;
            char_noise_reg <= 1'b0;
        end
        else if (srst)
        begin
            // Soft reset returns to search
            state_reg <= adr_pkg::ADR_SEARCH;
            phase_reg <= 4'h0;
            hist_reg <= 3'b000;
        end
        else if (clk_en)
        begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            if (tick)
                hist_reg <= {hist_reg[1:0], sample};
            if (tick && in_start && (phase_reg == `ADR_PH3 || phase_reg == `ADR_PH5))
                vs_reg <= {vs_reg[0], sample};
            if (tick && !in_search && (phase_reg == `ADR_PH8 || phase_reg == `ADR_PH9))
                ds_reg <= {ds_reg[0], sample};
            if (bit_end && in_start)
                bitcnt_reg <= 4'h0;
            else if (bit_end && in_data)
                bitcnt_reg <= bitcnt_reg + 4'h1;
            if (vote_pt && in_data)
                shift_reg <= {bit_maj, shift_reg[8:1]};
            char_noise_reg <= start_edge ? 1'b0 : (char_noise_reg | noise_now);
        end
    end

    // Falling-edge tracker used for in-character resync
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            watch_reg <= 1'b0;
            edge_seen_reg <= 1'b0;
            edge_age_reg <= 4'h0;
        end
        else if (clk_en)
        begin
            if (vote_pt || start_edge)
                watch_reg <= vote_pt & in_data & bit_maj;
            if (vote_pt || start_edge)
                edge_seen_reg <= 1'b0;
            else if (fall_edge)
                edge_seen_reg <= 1'b1;
            // Age saturates so a stale edge never resyncs
            if (fall_edge)
                edge_age_reg <= 4'h0;
            else if (tick && edge_age_reg != 4'hF)
                edge_age_reg <= edge_age_reg + 4'h1;
        end
    end

    // Quiet counting, status flags, standby and data buffer
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            idle_cnt_reg <= 4'h0;
            idle_armed_reg <= 1'b0;
            ctrl_reg <= `ADR_CTRL_RST;
            standby_request_bit_reg <= 1'b0;
            rx_full_flag_reg <= 1'b0;
            quiet_flag_reg <= 1'b0;
            noise_flag_reg <= 1'b0;
            framing_fault_flag_reg <= 1'b0;
            rx_data_buffer_reg <= 9'h000;
        end
        else if (clk_en)
        begin
            idle_cnt_reg <= srst ? 4'h0 : idle_cnt_next;
            // Armed by real traffic so a quiet line flags once per gap
            idle_armed_reg <= ~srst & (start_edge | (idle_armed_reg & ~idle_hit & ~idle_wake));
            if (wr_ctrl)
                ctrl_reg <= {1'b0, s_axi_wdata_ctl(wdata_reg)};
            // A software write of the standby bit wins over a same-cycle wakeup
            if (srst)
                standby_request_bit_reg <= 1'b0;
            else if (wr_ctrl)
                standby_request_bit_reg <= wdata_reg[`ADR_CTL_STBY];
            else if (addr_wake || idle_wake)
                standby_request_bit_reg <= 1'b0;
            // Flags: hardware set beats a same-cycle write-one clear
            rx_full_flag_reg <= ~srst & ((rx_full_flag_reg & ~flag_clr[`ADR_ST_FULL]) | deliver);
            quiet_flag_reg <= ~srst & ((quiet_flag_reg & ~flag_clr[`ADR_ST_QUIET]) | quiet_set);
            noise_flag_reg <= ~srst & ((noise_flag_reg & ~flag_clr[`ADR_ST_NOISE])
                              | (deliver & (char_noise_reg | bit_dis)));
            framing_fault_flag_reg <= ~srst & ((framing_fault_flag_reg & ~flag_clr[`ADR_ST_FRAME])
                                      | (deliver & ~bit_maj));
            if (deliver)
                rx_data_buffer_reg <= char_data;
        end
    end

    // Control image without the self-clearing soft reset bit; standby lives in its own register
    function automatic logic [6:0] s_axi_wdata_ctl(input logic [31:0] word);
        s_axi_wdata_ctl = {word[6], 1'b0, word[4:0]};
    endfunction : s_axi_wdata_ctl

    // Interrupt requests, silenced in standby
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            full_irq_reg <= 1'b0;
            quiet_irq_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            full_irq_reg <= rx_full_flag_reg & rx_full_irq_enable & ~standby_request_bit_reg;
            quiet_irq_reg <= quiet_flag_reg & quiet_irq_enable & ~standby_request_bit_reg;
        end
    end

    // AXI4-Lite slave: address and data taken in either order, one write and one read at a time
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            waddr_reg <= 32'h0000_0000;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `ADR_RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= `ADR_RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            if (aw_take)
                waddr_reg <= s_axi_awaddr;
            if (w_take)
            begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            awready_reg <= ~aw_held_next & ~bvalid_next;
            wready_reg <= ~w_held_next & ~bvalid_next;
            bvalid_reg <= bvalid_next;
            if (wr_do)
                bresp_reg <= w_hit ? `ADR_RESP_OKAY : `ADR_RESP_SLVERR;
            arready_reg <= ~rvalid_next;
            rvalid_reg <= rvalid_next;
            if (rd_take)
            begin
                rdata_reg <= rd_word;
                rresp_reg <= (r_ctrl | r_stat | r_data) ? `ADR_RESP_OKAY : `ADR_RESP_SLVERR;
            end
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign rx_full_irq = full_irq_reg;
    assign quiet_irq = quiet_irq_reg;

    // Checks on the recovery sequence, standby wakeup and soft reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_edge_found;
        start_edge && !srst;
    endsequence
    sequence s_verify_bad;
        start_fail && !srst;
    endsequence
    sequence s_frame_bad;
        deliver && !bit_maj && !srst;
    endsequence

    start_seen_a: assert property (s_edge_found |=> in_start && phase_reg == 4'h0)
        else $error("start edge did not begin phase count");
    verify_fail_a: assert property (s_verify_bad |=> in_search && phase_reg == 4'h0)
        else $error("failed start check did not restart search");
    verify_pass_a: assert property (verify_pt && !start_maj && !srst |=> in_start [*1] ##0 phase_reg == `ADR_PH8)
        else $error("good start check left start state");
    frame_full_a: assert property (s_frame_bad |=> framing_fault_flag_reg && rx_full_flag_reg)
        else $error("framing fault not raised with full flag");
    data_noise_a: assert property (vote_pt && in_data && bit_dis && !start_edge && !srst |=> char_noise_reg)
        else $error("disagreeing data samples not marked noisy");
    late_start_a: assert property (vote_pt && in_start && (bit_maj || bit_dis) && !srst
        |=> char_noise_reg && in_start)
        else $error("late start ones changed start handling");
    standby_quiet_a: assert property (standby_request_bit_reg && clk_en |=> !rx_full_irq && !quiet_irq)
        else $error("interrupt raised in standby");
    addr_wake_a: assert property (addr_wake && !wr_ctrl |=> !standby_request_bit_reg && rx_full_flag_reg)
        else $error("address mark did not wake and fill");
    idle_wake_a: assert property (idle_wake && !wr_ctrl |=> !standby_request_bit_reg && !$rose(quiet_flag_reg))
        else $error("quiet wakeup misbehaved");
    resync_pt_a: assert property (resync && !srst |=> phase_reg == $past(edge_age_reg) + 4'h1)
        else $error("resync phase wrong");
    quiet_set_a: assert property (quiet_set && !srst |=> quiet_flag_reg)
        else $error("quiet flag not set");
    soft_rst_a: assert property (srst |=> in_search && !standby_request_bit_reg && !rx_full_flag_reg)
        else $error("soft reset incomplete");
endmodule : adr_receiver

// ### sim/adr_tx_model.sv
// Remote serial transmitter model driving the receive line
`timescale 1ns/1ps
module adr_tx_model
(
    input wire logic clk,
    input wire logic tick,
    output logic line
);
    initial line = 1'h1; // Line idles high between frames
    // Drive a level for n ticks, changed just after a tick edge
    task automatic hold(input logic v, input int n);
        repeat (n) @(posedge clk iff tick) line <= v;
    endtask : hold
    // Start, data LSB first, stop sv; bit g gets phase nine flipped as noise
    task automatic send(input logic [8:0] d, input int nb, input logic sv, input int g);
        for (int i = 0; i <= nb + 1; i++)
            for (int k = 0; k < 16; k++)
                hold(((i == 0) ? 1'h0 : (i > nb) ? sv : d[i - 1]) ^ (i == g && k == 8), 1);
        hold(1'h1, 1);
    endtask : send
endmodule : adr_tx_model

// ### sim/adr_receiver_tb.sv
// Self-checking bench for the oversampling receiver
`timescale 1ns/1ps
`include "adr_params.svh"
module adr_receiver_tb;
    localparam logic [31:0] C = `ADR_OFF_CTRL, S = `ADR_OFF_STAT, D = `ADR_OFF_DATA;
    logic clk = 1'h0, sys_rst = 1'h1, tick = 1'h0, rx, awready, wready, bvalid, arready, rvalid, f_irq, q_irq;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, seed = 32'h8821_04ba;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [1:0] bresp, rresp, rs, tc = 2'h0;
    int err_total = 0, n_checks = 0;
    initial forever #2.5 clk = ~clk;
    // Tick every fourth clock keeps characters short
    always @(posedge clk) {tick, tc} <= {tc == 2'h3, tc + 2'h1};
    adr_tx_model tx_u (.clk(clk), .tick(tick), .line(rx));
    adr_receiver dut_u (.clk(clk), .sys_rst(sys_rst), .clk_en(1'h1), .oversample_tick(tick), .rx_pin(rx),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rx_full_irq(f_irq), .quiet_irq(q_irq));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction : xs
    // Expected control and status words
    function automatic logic [31:0] cfg(input logic l, w, q, f, i, s);
        return {26'h0, s, i, f, q, w, l};
    endfunction : cfg
    function automatic logic [31:0] st(input logic f, q, n, e, s);
        return {27'h0, s, e, n, q, f};
    endfunction : st
    // Write: address and data each released when taken, in either order
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        {awaddr, wdata, awvalid, wvalid} <= {a, v, 2'h3};
        fork
            @(posedge clk iff awready) awvalid <= 1'h0;
            @(posedge clk iff wready) wvalid <= 1'h0;
        join
        bready <= 1'h1;
        @(posedge clk iff bvalid);
        bready <= 1'h0;
        rs = bresp;
    endtask : wr
    task automatic rchk(input logic [31:0] a, input logic [31:0] e);
        {araddr, arvalid} <= {a, 1'h1};
        @(posedge clk iff arready);
        {arvalid, rready} <= 2'h1;
        @(posedge clk iff rvalid);
        rready <= 1'h0;
        rs = rresp;
        check(rdata, e);
    endtask : rchk
    initial
    begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'h0;
        rchk(C, 32'h0000_0000);
        rchk(32'h0000_000C, 32'h0000_0000);
        check({30'h0, rs}, {30'h0, `ADR_RESP_SLVERR});
        wr(32'h0000_000C, 32'h0000_0000);
        check({30'h0, rs}, {30'h0, `ADR_RESP_SLVERR});
        // Random characters; noise injected on start or first data bit
        repeat (6)
        begin
            seed = xs(seed);
            wr(C, cfg(seed[9], 1'h0, 1'h1, 1'h1, 1'h0, 1'h0));
            tx_u.send(seed[8:0], 8 + seed[9], 1'h1, seed[11] ? int'(seed[12]) : -1);
            check({31'h0, f_irq}, 32'h0000_0001);
            rchk(D, {23'h0, seed[8] & seed[9], seed[7:0]});
            rchk(S, st(1'h1, 1'h0, seed[11], 1'h0, 1'h0));
            wr(S, 32'h0000_000F);
        end
        $display("test characters done");
        // Runt pulse fails start, then break, then soft reset
        tx_u.hold(1'h0, 2);
        tx_u.hold(1'h1, 20);
        tx_u.send(9'h000, 8, 1'h0, -1);
        rchk(D, 32'h0000_0000);
        rchk(S, st(1'h1, 1'h0, 1'h0, 1'h1, 1'h0));
        wr(C, 32'h0000_0080);
        rchk(S, 32'h0000_0000);
        $display("test framing done");
        wr(C, cfg(1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1));
        // Noisy start on an ignored character, noisy first bit on the address mark
        tx_u.send(9'h005, 8, 1'h1, 0);
        rchk(S, st(1'h0, 1'h0, 1'h0, 1'h0, 1'h1));
        tx_u.send(9'h085, 8, 1'h1, 1);
        rchk(S, st(1'h1, 1'h0, 1'h1, 1'h0, 1'h0));
        check({31'h0, f_irq}, 32'h0000_0001);
        wr(C, cfg(1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1));
        @(posedge clk);
        check({31'h0, f_irq}, 32'h0000_0000);
        $display("test address mark done");
        // Five idle bits tell the two quiet count starts apart
        for (int qs = 0; qs < 2; qs++)
        begin
            wr(S, 32'h0000_000F);
            wr(C, cfg(1'h1, 1'h0, qs[0], 1'h0, 1'h1, 1'h0));
            tx_u.send(9'h1FF, 9, 1'h1, -1);
            tx_u.hold(1'h1, 80);
            rchk(S, st(1'h1, !qs[0], 1'h0, 1'h0, 1'h0));
            tx_u.hold(1'h1, 128);
            check({31'h0, q_irq}, 32'h0000_0001);
        end
        wr(S, 32'h0000_000F);
        wr(C, cfg(1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1));
        tx_u.hold(1'h1, 32);
        rchk(S, 32'h0000_0000);
        rchk(C, cfg(1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0));
        $display("test quiet line done");
        stop_test();
    end
    initial
    begin
        #400_000;
        err_total++;
        stop_test();
    end
endmodule : adr_receiver_tb
